// ==== verilog/scsq_pkg.sv ====
// scsq_pkg: constants, types and register map of the scsi sequence control block
// assumes a single 200 MHz core clock and an avalon-mm register port
// ============================================================
package scsq_pkg;

  // ============================================================
  // register map (byte addresses)
  localparam logic [4:0] SCSQ_OFF_SEQ    = 5'h00;
  localparam logic [4:0] SCSQ_OFF_STAT0  = 5'h04;
  localparam logic [4:0] SCSQ_OFF_STAT1  = 5'h08;
  localparam logic [4:0] SCSQ_OFF_IDPAIR = 5'h0c;
  localparam logic [4:0] SCSQ_OFF_MASK   = 5'h10;
  localparam logic [4:0] SCSQ_OFF_XFER1  = 5'h14;
  localparam logic [4:0] SCSQ_OFF_CLR1   = 5'h18;

  // ============================================================
  // field positions
  localparam int SEQ_ROLE_SEL   = 7; // outgoing_role_select
  localparam int SEQ_SEL_OUT    = 6; // outgoing_selection_enable
  localparam int SEQ_SEL_IN     = 5; // incoming_selection_enable
  localparam int SEQ_RESEL_IN   = 4; // incoming_reselection_enable
  localparam int SEQ_ATN_SEL    = 3; // auto_attention_on_selection
  localparam int SEQ_ATN_RESEL  = 2; // auto_attention_on_reselection
  localparam int SEQ_ATN_PAR    = 1; // auto_attention_on_parity
  localparam int SEQ_RST_OUT    = 0; // bus_reset_out
  localparam int ST0_IN_PROG    = 4;
  localparam int ST0_SEL_IN     = 5;
  localparam int ST0_SEL_DONE   = 6;
  localparam int ST0_TARGET     = 7;
  localparam int ST1_ATN        = 0;
  localparam int ST1_TIMEOUT    = 7;
  localparam int XF1_HW_TMO_EN  = 2;
  localparam int XF1_PAR_CHK_EN = 5;
  localparam int CLR1_SEL_IN    = 5;
  localparam int CLR1_ATN       = 6;
  localparam int CLR1_TIMEOUT   = 7;

  // ============================================================
  // reset values and timing
  localparam logic [7:0]  SCSQ_SEQ_RST      = 8'h00;
  localparam logic [15:0] SCSQ_MASK_RST     = 16'h0000;
  localparam int          SCSQ_CLK_MHZ      = 200;
  localparam int          SCSQ_SEL_TMO_US   = 250;
  localparam int          SCSQ_SEL_TMO_CYC  = SCSQ_SEL_TMO_US * SCSQ_CLK_MHZ;

  // ============================================================
  // types
  typedef enum logic [2:0] {
    SQ_IDLE, SQ_WAIT_FREE, SQ_SEL_WAIT, SQ_SEL_DONE, SQ_SEL_TMO, SQ_RESPOND
  } scsq_fsm_t;

  typedef struct packed {
    logic        bsy;
    logic        sel;
    logic        rst;
    logic        io;
    logic        req;
    logic [15:0] data;
    logic [1:0]  par;
  } scsq_pins_t;

  typedef struct packed {
    logic [7:0]  seq;
    logic [7:0]  id_pair;
    logic [15:0] mask;
    logic [7:0]  xfer1;
    logic        in_prog;
    logic        sel_done;
    logic        sel_tmo;
    logic        sel_in;
    logic        target;
    logic        atn;
    scsq_fsm_t   fsm;
    logic [31:0] tmo_cnt;
    scsq_pins_t  pin_m;
    scsq_pins_t  pin_s;
    logic        req_prev;
    logic        wait_n;
    logic [31:0] rdata;
    logic        bsy_oe;
    logic        sel_oe;
    logic        io_oe;
    logic        data_oe;
    logic [15:0] data_out;
  } scsq_state_t;

endpackage

// ==== verilog/scsq_seq_ctrl.sv ====
// scsq_seq_ctrl: scsi sequence control register and its selection hardware
// assumes bus pins are asynchronous and a sequencer drives the avalon port
//
// The Avalon-MM slave port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module scsq_seq_ctrl
  import scsq_pkg::*;
#(
  parameter int SEL_TMO_CYC = SCSQ_SEL_TMO_CYC
) (
  // clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  // avalon-mm slave
  input  wire logic [4:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  // scsi bus inputs (asynchronous)
  input  wire logic        scsi_bsy_i,
  input  wire logic        scsi_sel_i,
  input  wire logic        scsi_rst_i,
  input  wire logic        scsi_io_i,
  input  wire logic        scsi_req_i,
  input  wire logic [15:0] scsi_data_i,
  input  wire logic [1:0]  scsi_par_i,
  // scsi bus drivers, enable high drives the line asserted
  output logic             scsi_bsy_oe_o,
  output logic             scsi_sel_oe_o,
  output logic             scsi_atn_oe_o,
  output logic             scsi_rst_oe_o,
  output logic             scsi_io_oe_o,
  output logic      [15:0] scsi_data_o,
  output logic             scsi_data_oe_o
);

  scsq_state_t s_q;
  scsq_state_t s_d;

  // ============================================================
  // decoded bus conditions
  logic        acc;
  logic        wr_seq;
  logic        wr_clr;
  logic [15:0] own_bit;
  logic [15:0] peer_bit;
  logic        bus_free;
  logic        bus_rst;
  logic        sel_match;
  logic        sel_evt;
  logic        resel_evt;
  logic        par_evt;
  logic        atn_set;
  logic        atn_clr;

  assign acc       = (avs_read_i || avs_write_i) && !s_q.wait_n;
  assign wr_seq    = avs_write_i && s_q.wait_n && avs_address_i == SCSQ_OFF_SEQ
                     && avs_byteenable_i[0];
  assign wr_clr    = avs_write_i && s_q.wait_n && avs_address_i == SCSQ_OFF_CLR1
                     && avs_byteenable_i[0];
  assign own_bit   = 16'h0001 << s_q.id_pair[3:0];
  assign peer_bit  = 16'h0001 << s_q.id_pair[7:4];
  assign bus_free  = !s_q.pin_s.bsy && !s_q.pin_s.sel;
  assign bus_rst   = s_q.pin_s.rst;
  assign sel_match = |(s_q.pin_s.data & (own_bit | s_q.mask));
  // outgoing enable has priority in idle, so no response is taken then
  assign sel_evt   = s_q.fsm == SQ_IDLE && !s_q.seq[SEQ_SEL_OUT] && s_q.seq[SEQ_SEL_IN]
                     && s_q.pin_s.sel && !s_q.pin_s.bsy && !s_q.pin_s.io && sel_match;
  assign resel_evt = s_q.fsm == SQ_IDLE && !s_q.seq[SEQ_SEL_OUT] && s_q.seq[SEQ_RESEL_IN]
                     && s_q.pin_s.sel && !s_q.pin_s.bsy && s_q.pin_s.io
                     && |(s_q.pin_s.data & own_bit);
  assign par_evt   = s_q.seq[SEQ_ATN_PAR] && s_q.xfer1[XF1_PAR_CHK_EN] && !s_q.target
                     && s_q.pin_s.io && s_q.pin_s.req && !s_q.req_prev
                     && (!(^{s_q.pin_s.data[7:0], s_q.pin_s.par[0]})
                         || !(^{s_q.pin_s.data[15:8], s_q.pin_s.par[1]}));
  assign atn_set   = par_evt
                     || (resel_evt && s_q.seq[SEQ_ATN_RESEL])
                     || (s_q.fsm == SQ_WAIT_FREE && bus_free && !bus_rst
                         && !s_q.seq[SEQ_ROLE_SEL] && s_q.seq[SEQ_ATN_SEL]);
  // attention clear sources
  // own selection start looks free until the synced lines catch up
  assign atn_clr   = (wr_clr && avs_writedata_i[CLR1_ATN])
                     || (bus_free && s_q.fsm != SQ_WAIT_FREE && s_q.fsm != SQ_SEL_WAIT);

  // ============================================================
  // next state
  always_comb begin
    s_d = s_q;

    // two-stage pin synchroniser
    s_d.pin_m    = '{bsy: scsi_bsy_i, sel: scsi_sel_i, rst: scsi_rst_i, io: scsi_io_i,
                     req: scsi_req_i, data: scsi_data_i, par: scsi_par_i};
    s_d.pin_s    = s_q.pin_m;
    s_d.req_prev = s_q.pin_s.req;

    // avalon: one wait cycle, then accept
    s_d.wait_n = acc;
    s_d.rdata  = 32'h0000_0000;
    if (acc) begin
      unique case (avs_address_i)
        SCSQ_OFF_SEQ:    s_d.rdata[7:0]  = s_q.seq;
        SCSQ_OFF_STAT0:  s_d.rdata[7:0]  = {s_q.target, s_q.sel_done, s_q.sel_in,
                                            s_q.in_prog, 4'h0};
        SCSQ_OFF_STAT1:  s_d.rdata[7:0]  = {s_q.sel_tmo, 6'h00, s_q.atn};
        SCSQ_OFF_IDPAIR: s_d.rdata[7:0]  = s_q.id_pair;
        SCSQ_OFF_MASK:   s_d.rdata[15:0] = s_q.mask;
        SCSQ_OFF_XFER1:  s_d.rdata[7:0]  = s_q.xfer1;
        default:         s_d.rdata       = 32'h0000_0000;
      endcase
    end
    if (avs_write_i && s_q.wait_n) begin
      unique case (avs_address_i)
        SCSQ_OFF_IDPAIR: if (avs_byteenable_i[0]) s_d.id_pair = avs_writedata_i[7:0];
        SCSQ_OFF_XFER1:  if (avs_byteenable_i[0]) s_d.xfer1 = avs_writedata_i[7:0];
        SCSQ_OFF_MASK: begin
          if (avs_byteenable_i[0]) s_d.mask[7:0] = avs_writedata_i[7:0];
          if (avs_byteenable_i[1]) s_d.mask[15:8] = avs_writedata_i[15:8];
        end
        default: ;
      endcase
    end

    // control written by the sequencer; bus reset clears all bits but bus_reset_out
    if (wr_seq)
      s_d.seq = avs_writedata_i[7:0];
    if (bus_rst)
      s_d.seq[7:1] = 7'h00;

    // clear bits first, hardware sets below win
    if (wr_clr && avs_writedata_i[CLR1_SEL_IN])
      s_d.sel_in = 1'h0;
    if (wr_clr && avs_writedata_i[CLR1_TIMEOUT])
      s_d.sel_tmo = 1'h0;
    if (atn_clr)
      s_d.atn = 1'h0;
    if (atn_set)
      s_d.atn = 1'h1;

    s_d.tmo_cnt = 32'h0000_0000;
    unique case (s_q.fsm)
      SQ_IDLE: begin
        s_d.in_prog  = 1'h0;
        s_d.sel_done = 1'h0;
        if (s_q.seq[SEQ_SEL_OUT] && !bus_rst) begin
          s_d.fsm = SQ_WAIT_FREE;
        end else if (sel_evt) begin
          s_d.sel_in = 1'h1;
          s_d.target = 1'h1;
          s_d.bsy_oe = 1'h1;
          s_d.fsm    = SQ_RESPOND;
        end else if (resel_evt) begin
          s_d.sel_in = 1'h1;
          s_d.target = 1'h0;
          s_d.bsy_oe = 1'h1;
          s_d.fsm    = SQ_RESPOND;
        end
      end
      SQ_WAIT_FREE: begin
        if (!s_q.seq[SEQ_SEL_OUT]) begin
          s_d.fsm = SQ_IDLE;
        end else if (bus_free) begin
          s_d.sel_oe   = 1'h1;
          s_d.io_oe    = s_q.seq[SEQ_ROLE_SEL];
          s_d.data_out = own_bit | peer_bit;
          s_d.data_oe  = 1'h1;
          s_d.target   = s_q.seq[SEQ_ROLE_SEL];
          s_d.in_prog  = 1'h1;
          s_d.fsm      = SQ_SEL_WAIT;
        end
      end
      SQ_SEL_WAIT: begin
        s_d.tmo_cnt = s_q.tmo_cnt + 32'h0000_0001;
        if (s_q.pin_s.bsy) begin
          s_d.in_prog  = 1'h0;
          s_d.sel_done = 1'h1;
          s_d.sel_oe   = 1'h0;
          s_d.data_oe  = 1'h0;
          s_d.bsy_oe   = s_q.seq[SEQ_ROLE_SEL];
          s_d.fsm      = SQ_SEL_DONE;
        end else if (s_q.xfer1[XF1_HW_TMO_EN] && s_q.tmo_cnt >= 32'(SEL_TMO_CYC - 1)) begin
          s_d.in_prog = 1'h0;
          s_d.sel_tmo = 1'h1;
          s_d.sel_oe  = 1'h0;
          s_d.io_oe   = 1'h0;
          s_d.data_oe = 1'h0;
          s_d.fsm     = SQ_SEL_TMO;
        end
      end
      SQ_SEL_DONE, SQ_SEL_TMO: begin
        // held until the sequencer clears the enable
        if (!s_q.seq[SEQ_SEL_OUT]) begin
          s_d.bsy_oe = 1'h0;
          s_d.io_oe  = 1'h0;
          s_d.fsm    = SQ_IDLE;
        end
      end
      SQ_RESPOND: begin
        if (!s_q.sel_in)
          s_d.bsy_oe = 1'h0;
        if (!s_q.sel_in && !s_q.pin_s.sel)
          s_d.fsm = SQ_IDLE;
      end
    endcase

    // bus reset releases bsy, sel, io and data, but not attention or our own reset
    if (bus_rst) begin
      s_d.fsm     = SQ_IDLE;
      s_d.in_prog = 1'h0;
      s_d.bsy_oe  = 1'h0;
      s_d.sel_oe  = 1'h0;
      s_d.io_oe   = 1'h0;
      s_d.data_oe = 1'h0;
    end

    if (rst_i) begin
      s_d          = '0;
      s_d.seq      = SCSQ_SEQ_RST;
      s_d.mask     = SCSQ_MASK_RST;
      s_d.fsm      = SQ_IDLE;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    s_q <= s_d;
  end

  // ============================================================
  // outputs
  assign avs_readdata_o    = s_q.rdata;
  assign avs_waitrequest_o = !s_q.wait_n;
  assign scsi_bsy_oe_o     = s_q.bsy_oe;
  assign scsi_sel_oe_o     = s_q.sel_oe;
  assign scsi_atn_oe_o     = s_q.atn;
  assign scsi_rst_oe_o     = s_q.seq[SEQ_RST_OUT];
  assign scsi_io_oe_o      = s_q.io_oe;
  assign scsi_data_o       = s_q.data_out;
  assign scsi_data_oe_o    = s_q.data_oe;

  // ============================================================
  // assertions
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  property p_rst_out;
    (wr_seq && avs_writedata_i[SEQ_RST_OUT]) |=> scsi_rst_oe_o;
  endproperty
  a_rst_out: assert property (p_rst_out) else $error("reset out not driven");

  property p_bus_rst_clear;
    (bus_rst && !wr_seq) |=> s_q.seq[7:1] == 7'h00 && s_q.seq[0] == $past(s_q.seq[0]);
  endproperty
  a_bus_rst_clear: assert property (p_bus_rst_clear) else $error("bus reset clear wrong");

  property p_in_prog;
    s_q.fsm == SQ_SEL_WAIT |-> s_q.in_prog && s_q.sel_oe;
  endproperty
  a_in_prog: assert property (p_in_prog) else $error("in-progress flag missing");

  property p_sel_ids;
    (s_q.fsm == SQ_WAIT_FREE && bus_free && !bus_rst && s_q.seq[SEQ_SEL_OUT])
      |=> s_q.sel_oe && s_q.data_out == $past(own_bit | peer_bit);
  endproperty
  a_sel_ids: assert property (p_sel_ids) else $error("selection ids wrong");

  property p_atn_clear;
    (atn_clr && !atn_set) |=> !scsi_atn_oe_o;
  endproperty
  a_atn_clear: assert property (p_atn_clear) else $error("attention not cleared");

  property p_atn_hold;
    (s_q.atn && !atn_clr) |=> s_q.atn;
  endproperty
  a_atn_hold: assert property (p_atn_hold) else $error("attention dropped");

  property p_sel_in;
    (sel_evt && !bus_rst) |=> s_q.sel_in && s_q.target && s_q.fsm == SQ_RESPOND;
  endproperty
  a_sel_in: assert property (p_sel_in) else $error("selection in not flagged");

  property p_resel_in;
    (resel_evt && !bus_rst) |=> s_q.sel_in && !s_q.target ##1 s_q.bsy_oe || !s_q.sel_in;
  endproperty
  a_resel_in: assert property (p_resel_in) else $error("reselection in wrong");

  property p_sel_out_hold;
    $fell(s_q.seq[SEQ_SEL_OUT]) |-> $past(wr_seq) || $past(bus_rst);
  endproperty
  a_sel_out_hold: assert property (p_sel_out_hold) else $error("enable cleared by itself");

endmodule // scsq_seq_ctrl

`default_nettype wire

// ==== bench/scsq_peer.sv ====
// scsq_peer: behavioural scsi device on the far side of the sequence control block
// assumes lines read 1 when asserted and 0 when nobody drives them (terminated)
`timescale 1ns/1ps
`default_nettype none

module scsq_peer
  import scsq_pkg::*;
(
  // clock
  input  wire logic        clk_i,
  // bench control
  input  wire logic [2:0]  mode_i,
  input  wire logic [15:0] ids_i,
  // bus view and drive
  input  wire logic        hit_i,
  output scsq_pins_t       pins_o
);
  logic [4:0] wait_q;

  // ============================================================
  // modes: 1 slow busy answer, 2 select, 3 reselect, 5 data in
  always_ff @(posedge clk_i) begin
    pins_o <= '0;
    if (mode_i != 3'd1) begin
      wait_q <= 5'd0;
    end else if (wait_q != 5'd16 && (hit_i || wait_q != 5'd0)) begin
      wait_q <= wait_q + 5'd1;
    end
    case (mode_i)
      3'd1: pins_o.bsy <= (wait_q == 5'd16);
      3'd2, 3'd3: begin
        pins_o.sel  <= 1'b1;
        pins_o.io   <= (mode_i == 3'd3);
        pins_o.data <= ids_i;
        pins_o.par  <= {~^ids_i[15:8], ~^ids_i[7:0]};
      end
      3'd5: begin
        pins_o.bsy  <= 1'b1;
        pins_o.io   <= 1'b1;
        pins_o.req  <= ~pins_o.req;
        pins_o.data <= ids_i;
        pins_o.par  <= {^ids_i[15:8], ^ids_i[7:0]};
      end
      default: pins_o.bsy <= 1'b0;
    endcase
  end
endmodule // scsq_peer

`default_nettype wire

// ==== bench/tb_scsq_seq_ctrl.sv ====
// tb_scsq_seq_ctrl: register-level bench for the sequence control block
// assumes scsq_peer on the bus; wire level is the or of all drivers
`timescale 1ns/1ps
`default_nettype none

module tb_scsq_seq_ctrl
  import scsq_pkg::*;
;
  localparam int I_BSY = 5;
  localparam int I_SEL = 4;
  localparam int I_ATN = 3;
  localparam int I_RST = 2;
  localparam int I_IO  = 1;

  logic        ref_clk = 1'b0;
  logic        rst     = 1'b1;
  logic [4:0]  addr    = 5'h00;
  logic        rd_r    = 1'b0;
  logic        wr_r    = 1'b0;
  logic [31:0] wdata   = 32'h0;
  logic [3:0]  be      = 4'h0;
  logic [2:0]  mode    = 3'd0;
  logic [15:0] ids     = 16'h0;
  logic [31:0] rdata;
  logic [31:0] q;
  logic        wreq;
  logic        bsy_oe;
  logic        sel_oe;
  logic        atn_oe;
  logic        rst_oe;
  logic        io_oe;
  logic        data_oe;
  logic [15:0] dout;
  scsq_pins_t  pins;
  int          errors     = 0;
  int          n_compared = 0;
  wire logic [5:0] obs = {bsy_oe, sel_oe, atn_oe, rst_oe, io_oe, data_oe};

  always #2.5 ref_clk = ~ref_clk;

  scsq_peer peer_u (.clk_i(ref_clk), .mode_i(mode), .ids_i(ids),
                    .hit_i(sel_oe & dout[2]), .pins_o(pins));

  scsq_seq_ctrl #(.SEL_TMO_CYC(20)) dut_u (
    .ref_clk_i(ref_clk), .rst_i(rst), .avs_address_i(addr), .avs_read_i(rd_r),
    .avs_write_i(wr_r), .avs_writedata_i(wdata), .avs_byteenable_i(be),
    .avs_readdata_o(rdata), .avs_waitrequest_o(wreq),
    .scsi_bsy_i(pins.bsy | bsy_oe), .scsi_sel_i(pins.sel | sel_oe),
    .scsi_rst_i(pins.rst | rst_oe), .scsi_io_i(pins.io | io_oe),
    .scsi_req_i(pins.req), .scsi_data_i(pins.data | (data_oe ? dout : 16'h0)),
    .scsi_par_i(pins.par), .scsi_bsy_oe_o(bsy_oe), .scsi_sel_oe_o(sel_oe),
    .scsi_atn_oe_o(atn_oe), .scsi_rst_oe_o(rst_oe), .scsi_io_oe_o(io_oe),
    .scsi_data_o(dout), .scsi_data_oe_o(data_oe));

  // ============================================================
  // tasks
  task automatic report_and_stop();
    $display("compared=%0d errors=%0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] msk);
    n_compared++;
    if ((got & msk) !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got & msk, exp);
    end
  endtask

  task automatic acc(input logic w, input logic [4:0] a, input logic [31:0] d,
                     input logic [3:0] b);
    int n;
    n = 0;
    addr  <= a;
    wr_r  <= w;
    rd_r  <= ~w;
    wdata <= d;
    be    <= b;
    do begin
      @(posedge ref_clk);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    q = rdata;
    wr_r <= 1'b0;
    rd_r <= 1'b0;
    if (n >= 50) begin
      errors++;
      report_and_stop();
    end
    @(posedge ref_clk);
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] b);
    acc(1'b1, a, d, b);
  endtask

  task automatic rd(input logic [4:0] a, input logic [31:0] e, input logic [31:0] m);
    acc(1'b0, a, 32'h0, 4'hf);
    chk(q, e, m);
  endtask

  // bounded wait for a bus driver, then compare its level
  task automatic pin(input int i, input logic v);
    int n;
    n = 0;
    while (obs[i] !== v && n < 200) begin
      @(posedge ref_clk);
      n++;
    end
    chk({31'h0, obs[i]}, {31'h0, v}, 32'h1);
    if (obs[i] !== v) begin
      report_and_stop();
    end
  endtask

  // ============================================================
  // tests
  initial begin
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    rd(SCSQ_OFF_SEQ, 32'h0, 32'hff);
    rd(SCSQ_OFF_STAT0, 32'h0, 32'hf0);
    rd(5'h1c, 32'h0, 32'hffffffff);
    wr(SCSQ_OFF_SEQ, 32'h30, 4'h0);
    rd(SCSQ_OFF_SEQ, 32'h0, 32'hff);
    $display("end of reset and access test");
    mode <= 3'd1;
    wr(SCSQ_OFF_IDPAIR, 32'h21, 4'h1);
    wr(SCSQ_OFF_SEQ, 32'h48, 4'h1);
    pin(I_SEL, 1'b1);
    chk({16'h0, dout}, 32'h6, 32'hffff);
    pin(I_IO, 1'b0);
    pin(I_ATN, 1'b1);
    rd(SCSQ_OFF_STAT0, 32'h10, 32'h50);
    pin(I_SEL, 1'b0);
    rd(SCSQ_OFF_STAT0, 32'h40, 32'h50);
    rd(SCSQ_OFF_SEQ, 32'h48, 32'hff);
    wr(SCSQ_OFF_SEQ, 32'h0, 4'h1);
    repeat (8) @(posedge ref_clk);
    pin(I_ATN, 1'b1);
    wr(SCSQ_OFF_CLR1, 32'h40, 4'h1);
    pin(I_ATN, 1'b0);
    mode <= 3'd0;
    $display("end of selection out test");
    repeat (8) @(posedge ref_clk);
    mode <= 3'd1;
    wr(SCSQ_OFF_SEQ, 32'hc0, 4'h1);
    pin(I_IO, 1'b1);
    chk({16'h0, dout}, 32'h6, 32'hffff);
    pin(I_SEL, 1'b0);
    wr(SCSQ_OFF_SEQ, 32'h0, 4'h1);
    mode <= 3'd0;
    $display("end of reselection out test");
    repeat (8) @(posedge ref_clk);
    wr(SCSQ_OFF_MASK, 32'h0008, 4'h3);
    rd(SCSQ_OFF_MASK, 32'h0008, 32'hffff);
    wr(SCSQ_OFF_SEQ, 32'h20, 4'h1);
    ids  <= 16'h0028;
    mode <= 3'd2;
    pin(I_BSY, 1'b1);
    rd(SCSQ_OFF_STAT0, 32'ha0, 32'ha0);
    mode <= 3'd0;
    rd(SCSQ_OFF_SEQ, 32'h20, 32'hff);
    wr(SCSQ_OFF_CLR1, 32'h20, 4'h1);
    pin(I_BSY, 1'b0);
    $display("end of selection in test");
    wr(SCSQ_OFF_SEQ, 32'h14, 4'h1);
    ids  <= 16'h0006;
    mode <= 3'd3;
    pin(I_ATN, 1'b1);
    rd(SCSQ_OFF_STAT0, 32'h20, 32'ha0);
    wr(SCSQ_OFF_SEQ, 32'h0, 4'h1);
    rd(SCSQ_OFF_SEQ, 32'h0, 32'hff);
    wr(SCSQ_OFF_CLR1, 32'h20, 4'h1);
    mode <= 3'd0;
    pin(I_ATN, 1'b0);
    $display("end of reselection in test");
    wr(SCSQ_OFF_XFER1, 32'h20, 4'h1);
    wr(SCSQ_OFF_SEQ, 32'h02, 4'h1);
    ids  <= 16'h0155;
    mode <= 3'd5;
    pin(I_ATN, 1'b1);
    rd(SCSQ_OFF_STAT1, 32'h01, 32'h01);
    mode <= 3'd0;
    pin(I_ATN, 1'b0);
    $display("end of parity attention test");
    wr(SCSQ_OFF_XFER1, 32'h24, 4'h1);
    wr(SCSQ_OFF_SEQ, 32'h40, 4'h1);
    pin(I_SEL, 1'b1);
    pin(I_SEL, 1'b0);
    rd(SCSQ_OFF_STAT1, 32'h80, 32'h80);
    rd(SCSQ_OFF_STAT0, 32'h00, 32'h50);
    wr(SCSQ_OFF_SEQ, 32'h0, 4'h1);
    wr(SCSQ_OFF_CLR1, 32'h80, 4'h1);
    rd(SCSQ_OFF_STAT1, 32'h00, 32'h80);
    $display("end of selection timeout test");
    wr(SCSQ_OFF_SEQ, 32'hb1, 4'h1);
    pin(I_RST, 1'b1);
    repeat (6) @(posedge ref_clk);
    rd(SCSQ_OFF_SEQ, 32'h01, 32'hff);
    wr(SCSQ_OFF_SEQ, 32'h0, 4'h1);
    pin(I_RST, 1'b0);
    $display("end of bus reset test");
    report_and_stop();
  end
endmodule // tb_scsq_seq_ctrl

`default_nettype wire
